// ---- core/isa_pkg.sv ----
// shared constants and helpers for both ends of the expansion bus
package isa_pkg;
	localparam int ADDR_W        = 24;
	localparam int SA_W          = 20;
	localparam int LA_LO         = 17;
	localparam int DATA_W        = 16;
	localparam int SYNC_W        = 64;
	localparam int CLK_PERIOD_NS = 8;
	localparam longint CLK_HZ    = 125_000_000;
	localparam longint OSC_HZ    = 14_318_180;
	localparam int OSC_ACC_W     = 32;
	localparam logic [OSC_ACC_W-1:0] OSC_STEP = OSC_ACC_W'((OSC_HZ << OSC_ACC_W) / CLK_HZ);
	localparam int BUSCLK_HALF   = 5;
	localparam int REFRESH_NS    = 15000;
	localparam int REFRESH_CYC   = REFRESH_NS / CLK_PERIOD_NS;
	localparam int MASTER_MAX_NS = 15000;
	localparam int MASTER_MAX_CYC = MASTER_MAX_NS / CLK_PERIOD_NS;
	localparam logic [2:0] CMD_STD_BCLK = 3'h4;
	localparam logic [2:0] CMD_W16_BCLK = 3'h2;
	localparam logic [2:0] CMD_ZWS_BCLK = 3'h1;
	localparam logic [ADDR_W-1:0] LOW_MEG_LIMIT = 24'h10_0000;
	localparam int IRQ_N = 11;
	localparam logic [3:0] IRQ_ORDER [IRQ_N] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
	localparam int DMA_NO_CH = 4;
	localparam logic [SYNC_W-1:0] SYNC_RST = 64'hFFFF_FFFF_FFFF_FFFF;

	// first pending entry of IRQ_ORDER wins; bit 4 is set when any line listed in IRQ_ORDER is pending
	function automatic logic [4:0] irq_pick(input logic [15:0] req);
		logic [4:0] r;
		r = 5'h00;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (req[IRQ_ORDER[i]]) begin
				r = {1'b1, IRQ_ORDER[i]};
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] dma_pick(input logic [7:0] req);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			if (req[i] && i != DMA_NO_CH) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	// a bit moves only once the second and third stage agree
	function automatic logic [SYNC_W-1:0] settle(input logic [SYNC_W-1:0] s2, s3, cur);
		return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & cur);
	endfunction
endpackage

// ---- core/isa_link_if.sv ----
// expansion bus wiring between the host end and one card end
`timescale 1ns/1ps
interface isa_link_if;
	logic        busclk, osc, rstdrv, bale, aen, smemr_n, smemw_n, tc;
	logic [7:0]  dack_n;
	logic [19:0] host_sa_out;
	logic        host_sa_oe_n;
	logic [6:0]  host_la_out;
	logic        host_la_oe_n;
	logic [15:0] host_sd_out;
	logic        host_sd_oe_n;
	logic [4:0]  host_cmd_out;
	logic        host_cmd_oe_n;
	logic        host_refresh_out, host_refresh_oe_n;
	logic [15:0] card_irq;
	logic [7:0]  card_drq;
	logic [15:0] card_sd_out;
	logic        card_sd_oe_n;
	logic [3:0]  card_od_out;
	logic [3:0]  card_od_oe_n;
	logic        card_master_n;
	logic        card_refresh_out, card_refresh_oe_n;
	logic [19:0] sa;
	logic [6:0]  la;
	logic [15:0] sd;
	logic        sbhe_n, ior_n, iow_n, memr_n, memw_n, refresh_n;
	logic        iochck_n, memcs16_n, iocs16_n, zws_n;

	// released lines float high through pull-ups
	assign sa = host_sa_oe_n ? '1 : host_sa_out;
	assign la = host_la_oe_n ? '1 : host_la_out;
	assign sd = !host_sd_oe_n ? host_sd_out : (!card_sd_oe_n ? card_sd_out : '1);
	assign {sbhe_n, ior_n, iow_n, memr_n, memw_n} = host_cmd_oe_n ? 5'h1F : host_cmd_out;
	assign refresh_n = (host_refresh_oe_n | host_refresh_out) & (card_refresh_oe_n | card_refresh_out);
	assign {iochck_n, memcs16_n, iocs16_n, zws_n} = card_od_oe_n | card_od_out;

	modport host (
		output busclk, osc, rstdrv, bale, aen, smemr_n, smemw_n, tc, dack_n,
		output host_sa_out, host_sa_oe_n, host_la_out, host_la_oe_n, host_sd_out, host_sd_oe_n,
		output host_cmd_out, host_cmd_oe_n, host_refresh_out, host_refresh_oe_n,
		input  card_irq, card_drq, card_master_n, sd, refresh_n, iochck_n, memcs16_n, iocs16_n, zws_n
	);
	modport card (
		output card_irq, card_drq, card_sd_out, card_sd_oe_n, card_od_out, card_od_oe_n,
		output card_master_n, card_refresh_out, card_refresh_oe_n,
		input  busclk, rstdrv, bale, aen, tc, dack_n, sa, la, sd, sbhe_n, ior_n, iow_n, memr_n, memw_n, refresh_n
	);
endinterface

// ---- core/isa_host_end.sv ----
// host end of the expansion bus: cycles, dma, refresh, interrupts, reset drive
// How it works
// - cards latch sa on bale falling edge
// - bale held high during dma cycles
// - reset drive high on power, line, reset
// - la bits carried unlatched beside sa
// - bus high enable marks valid upper byte
// - low channel check reported as error
// - irq priority 9,10,11,12,13,15,3..7
// - io read strobe: device drives data
// - io write strobe: device takes data
// - system memory strobes only below one megabyte
// - memory strobes low for every memory access
// - dma channels 0-3 byte, 5-7 word
// - card holds drq until transfer done
// - dma grant fixed priority, zero highest
// - one low acknowledge per dma channel
// - aen high when dma owns address bus
// - refresh line marks refresh, master may drive
// - terminal count pulse when channel expires
// - master low no longer than 15 us
// - 16-bit selects mean one wait state
// - zero wait select ends cycle early
// - free running 14.31818 MHz oscillator out
`timescale 1ns/1ps
module isa_host_end
	import isa_pkg::*;
(
	input  wire logic                  clk_sys_in,
	input  wire logic                  rst_in,
	isa_link_if.host                   bus,
	input  wire logic                  power_good_in,
	input  wire logic                  hw_reset_in,
	input  wire logic                  cyc_valid_in,
	input  wire logic                  cyc_write_in,
	input  wire logic                  cyc_io_in,
	input  wire logic                  cyc_wide_in,
	input  wire logic [isa_pkg::ADDR_W-1:0] cyc_addr_in,
	input  wire logic [isa_pkg::DATA_W-1:0] cyc_wdata_in,
	output logic                       cyc_ready_out,
	output logic                       done_valid_out,
	output logic                       done_dma_out,
	output logic                       done_wide_out,
	output logic [isa_pkg::DATA_W-1:0] done_rdata_out,
	input  wire logic                  dma_load_in,
	input  wire logic [2:0]            dma_load_ch_in,
	input  wire logic [15:0]           dma_load_cnt_in,
	input  wire logic [isa_pkg::ADDR_W-1:0] dma_addr_in,
	input  wire logic                  dma_to_io_in,
	output logic                       dma_tc_out,
	output logic [2:0]                 dma_ch_out,
	output logic                       chck_err_out,
	output logic                       irq_any_out,
	output logic [3:0]                 irq_num_out
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_LATCH = 3'b010,
		ST_CMD = 3'b011, ST_END = 3'b100, ST_MASTER = 3'b101
	} state_t;
	typedef enum logic [1:0] {K_IO = 2'b00, K_MEM = 2'b01, K_DMA = 2'b10, K_REF = 2'b11} kind_t;

	state_t              state;
	kind_t               kind;
	logic [SYNC_W-1:0]   s1, s2, s3, sf;
	logic [2:0]          div;
	logic                tick;
	logic [OSC_ACC_W-1:0] osc_acc;
	logic [10:0]         ref_cnt;
	logic                ref_due;
	logic [7:0]          ref_row;
	logic [2:0]          bcnt;
	logic                write, wide, sel16;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic [2:0]          ch;
	logic [15:0]         dma_cnt [8];
	logic                last;
	logic [4:0]          irq_sel;
	logic [3:0]          drq_sel;
	logic [7:0]          drq_live;
	logic                master_s, zws_s, mcs_s, ics_s, chck_s, pgood_s, hwrst_s;
	logic [15:0]         irq_s, sd_s;
	logic [7:0]          drq_s;
	logic [2:0]          lim;

	assign {hwrst_s, pgood_s, master_s, zws_s, ics_s, mcs_s, chck_s, drq_s, irq_s, sd_s} = sf[46:0];
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			drq_live[i] = drq_s[i] && dma_cnt[i] != 16'h0000;
		end
	end
	assign irq_sel = irq_pick(irq_s);
	assign drq_sel = dma_pick(drq_live);
	assign lim = !zws_s ? CMD_ZWS_BCLK : (sel16 ? CMD_W16_BCLK : CMD_STD_BCLK);

	// three stages for every pin, settled copy used everywhere
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s1 <= SYNC_RST;
			s2 <= SYNC_RST;
			s3 <= SYNC_RST;
			sf <= SYNC_RST;
		end else begin
			s1 <= {17'h0_0000, hw_reset_in, power_good_in, bus.card_master_n, bus.zws_n, bus.iocs16_n,
				bus.memcs16_n, bus.iochck_n, bus.card_drq, bus.card_irq, bus.sd};
			s2 <= s1;
			s3 <= s2;
			sf <= settle(s2, s3, sf);
		end
	end

	// bus clock is a divide by ten, no second domain here
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			div <= 3'h0;
			bus.busclk <= 1'b0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (div == 3'(BUSCLK_HALF - 1)) begin
				div <= 3'h0;
				bus.busclk <= !bus.busclk;
				tick <= !bus.busclk;
			end else begin
				div <= div + 3'h1;
			end
		end
	end

	// phase accumulator: average rate exact, edges jitter by one clock
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			osc_acc <= '0;
			bus.osc <= 1'b0;
		end else begin
			osc_acc <= osc_acc + OSC_STEP;
			bus.osc <= osc_acc[OSC_ACC_W-1];
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			bus.rstdrv <= 1'b1;
		end else begin
			bus.rstdrv <= !pgood_s || hwrst_s;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			ref_cnt <= '0;
			ref_due <= 1'b0;
		end else begin
			if (ref_cnt == 11'(REFRESH_CYC - 1)) begin
				ref_cnt <= '0;
				ref_due <= 1'b1;
			end else begin
				ref_cnt <= ref_cnt + 11'h001;
				if (state == ST_ADDR && kind == K_REF) begin
					ref_due <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < 8; i++) begin
				dma_cnt[i] <= 16'h0000;
			end
		end else if (tick && state == ST_CMD && kind == K_DMA && bcnt + 3'h1 >= lim) begin
			dma_cnt[ch] <= dma_cnt[ch] - 16'h0001;
		end else if (dma_load_in && dma_load_ch_in != 3'(DMA_NO_CH)) begin
			dma_cnt[dma_load_ch_in] <= dma_load_cnt_in;
		end
	end

	// sequencer: address, latch and end phases last one bus clock; the command phase lasts lim bus clocks
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			kind <= K_IO;
			addr <= '0;
			wdata <= '0;
			write <= 1'b0;
			wide <= 1'b0;
			sel16 <= 1'b0;
			ch <= 3'h0;
			bcnt <= 3'h0;
			last <= 1'b0;
			ref_row <= 8'h00;
			cyc_ready_out <= 1'b0;
			done_valid_out <= 1'b0;
			done_dma_out <= 1'b0;
			done_wide_out <= 1'b0;
			done_rdata_out <= '0;
			dma_tc_out <= 1'b0;
		end else begin
			cyc_ready_out <= 1'b0;
			done_valid_out <= 1'b0;
			dma_tc_out <= 1'b0;
			if (tick) begin
				unique case (state)
					ST_IDLE: begin
						bcnt <= 3'h0;
						sel16 <= 1'b0;
						if (!master_s) begin
							state <= ST_MASTER;
						end else if (ref_due) begin
							state <= ST_ADDR;
							kind <= K_REF;
							addr <= {16'h0000, ref_row};
							ref_row <= ref_row + 8'h01;
							write <= 1'b0;
							wide <= 1'b0;
						end else if (drq_sel[3]) begin
							state <= ST_ADDR;
							kind <= K_DMA;
							ch <= drq_sel[2:0];
							addr <= dma_addr_in;
							wdata <= cyc_wdata_in;
							write <= dma_to_io_in;
							wide <= drq_sel[2];
							last <= dma_cnt[drq_sel[2:0]] == 16'h0001;
						end else if (cyc_valid_in) begin
							state <= ST_ADDR;
							kind <= cyc_io_in ? K_IO : K_MEM;
							addr <= cyc_addr_in;
							wdata <= cyc_wdata_in;
							write <= cyc_write_in;
							wide <= cyc_wide_in;
							cyc_ready_out <= 1'b1;
						end
					end
					ST_ADDR: state <= ST_LATCH;
					ST_LATCH: state <= ST_CMD;
					ST_CMD: begin
						bcnt <= bcnt + 3'h1;
						if ((kind == K_IO || kind == K_DMA) && !ics_s || kind == K_MEM && !mcs_s) begin
							sel16 <= 1'b1;
						end
						if (bcnt + 3'h1 >= lim) begin
							state <= ST_END;
							done_rdata_out <= sd_s;
							done_wide_out <= sel16 || !ics_s || !mcs_s;
							done_dma_out <= kind == K_DMA;
							done_valid_out <= kind != K_REF;
							dma_tc_out <= kind == K_DMA && last;
						end
					end
					ST_END: state <= ST_IDLE;
					ST_MASTER: begin
						if (master_s) begin
							state <= ST_IDLE;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// pins follow the sequencer one clock later, all from flops
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			bus.bale <= 1'b0;
			bus.aen <= 1'b0;
			bus.tc <= 1'b0;
			bus.dack_n <= 8'hFF;
			bus.smemr_n <= 1'b1;
			bus.smemw_n <= 1'b1;
			bus.host_sa_out <= '0;
			bus.host_sa_oe_n <= 1'b1;
			bus.host_la_out <= '0;
			bus.host_la_oe_n <= 1'b1;
			bus.host_sd_out <= '0;
			bus.host_sd_oe_n <= 1'b1;
			bus.host_cmd_out <= 5'h1F;
			bus.host_cmd_oe_n <= 1'b1;
			bus.host_refresh_out <= 1'b1;
			bus.host_refresh_oe_n <= 1'b1;
		end else begin
			logic cmd, rd, wr, mem, io, low;
			cmd = state == ST_CMD;
			mem = kind == K_MEM || kind == K_REF;
			io = kind == K_IO;
			rd = cmd && (kind == K_DMA ? !write : !write);
			wr = cmd && write;
			low = addr < LOW_MEG_LIMIT;
			bus.bale <= state == ST_ADDR || (kind == K_DMA && state != ST_IDLE && state != ST_MASTER);
			bus.aen <= kind == K_DMA && state != ST_IDLE && state != ST_MASTER;
			bus.dack_n <= ~(8'(kind == K_DMA && state != ST_IDLE && state != ST_MASTER) << ch);
			bus.tc <= kind == K_DMA && state == ST_END && last;
			bus.host_sa_out <= addr[SA_W-1:0];
			bus.host_la_out <= addr[ADDR_W-1:LA_LO];
			bus.host_sa_oe_n <= state == ST_IDLE || state == ST_MASTER;
			bus.host_la_oe_n <= state == ST_IDLE || state == ST_MASTER;
			bus.host_cmd_oe_n <= state == ST_MASTER;
			bus.host_cmd_out <= {
				!(wide && state != ST_IDLE),
				!(rd && (io || kind == K_DMA)),
				!(wr && (io || kind == K_DMA)),
				!(cmd && ((mem && !write) || (kind == K_DMA && write))),
				!(cmd && ((kind == K_MEM && write) || (kind == K_DMA && !write)))
			};
			bus.smemr_n <= !(cmd && low && ((mem && !write) || (kind == K_DMA && write)));
			bus.smemw_n <= !(cmd && low && ((kind == K_MEM && write) || (kind == K_DMA && !write)));
			bus.host_sd_out <= wdata;
			bus.host_sd_oe_n <= !(wr && kind != K_REF);
			bus.host_refresh_out <= !(kind == K_REF && state != ST_IDLE && state != ST_MASTER);
			bus.host_refresh_oe_n <= state == ST_MASTER;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			chck_err_out <= 1'b0;
			irq_any_out <= 1'b0;
			irq_num_out <= 4'h0;
			dma_ch_out <= 3'h0;
		end else begin
			chck_err_out <= !chck_s;
			irq_any_out <= irq_sel[4];
			irq_num_out <= irq_sel[3:0];
			dma_ch_out <= ch;
		end
	end
endmodule // isa_host_end

// ---- core/isa_card_end.sv ----
// card end of the expansion bus: one io word, dma requester, master request
`timescale 1ns/1ps
module isa_card_end
	import isa_pkg::*;
#(
	parameter logic [19:0] IO_BASE  = 20'h0_0300,
	parameter int          IRQ_LINE = 5,
	parameter int          DMA_CH   = 1,
	parameter bit          WIDE     = 1'b1,
	parameter bit          FAST     = 1'b0
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	isa_link_if.card         bus,
	input  wire logic [15:0] rd_data_in,
	output logic             wr_valid_out,
	output logic [15:0]      wr_data_out,
	input  wire logic        irq_in,
	input  wire logic        parity_err_in,
	input  wire logic        dma_req_in,
	output logic             dma_busy_out,
	input  wire logic        master_req_in,
	output logic             master_cut_out
);
	logic [SYNC_W-1:0] s1, s2, s3, sf;
	logic [19:0]       sa_s;
	logic [15:0]       sd_s;
	logic [7:0]        dack_s;
	logic              bale_s, aen_s, ior_s, iow_s, tc_s, rstdrv_s, refresh_s, bale_d, iow_d;
	logic              sel, acked, drq, iow_seen;
	logic [10:0]       mcnt;

	assign {refresh_s, rstdrv_s, tc_s, iow_s, ior_s, aen_s, bale_s, dack_s, sd_s, sa_s} = sf[50:0];
	assign acked = !dack_s[DMA_CH] && aen_s && refresh_s;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s1 <= SYNC_RST;
			s2 <= SYNC_RST;
			s3 <= SYNC_RST;
			sf <= SYNC_RST;
		end else begin
			s1 <= {13'h0000, bus.refresh_n, bus.rstdrv, bus.tc, bus.iow_n, bus.ior_n, bus.aen, bus.bale,
				bus.dack_n, bus.sd, bus.sa};
			s2 <= s1;
			s3 <= s2;
			sf <= settle(s2, s3, sf);
		end
	end

	// decode on the falling edge of bale, only for cpu cycles
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			bale_d <= 1'b0;
			sel <= 1'b0;
		end else begin
			bale_d <= bale_s;
			if (rstdrv_s) begin
				sel <= 1'b0;
			end else if (bale_d && !bale_s) begin
				sel <= !aen_s && sa_s[19:1] == IO_BASE[19:1];
			end
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			bus.card_sd_out <= '0;
			bus.card_sd_oe_n <= 1'b1;
			bus.card_od_out <= 4'h0;
			bus.card_od_oe_n <= 4'hF;
			bus.card_irq <= '0;
			bus.card_refresh_out <= 1'b1;
			bus.card_refresh_oe_n <= 1'b1;
		end else begin
			bus.card_sd_out <= rd_data_in;
			bus.card_sd_oe_n <= !(!ior_s && (sel || acked));
			bus.card_od_oe_n <= {!parity_err_in, 1'b1,
				!(WIDE && (sel || acked)),
				!(FAST && (sel || acked) && !(ior_s && iow_s))};
			bus.card_irq <= 16'(irq_in) << IRQ_LINE;
		end
	end

	// write data is taken while the strobe is low, reported at its release
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			iow_d <= 1'b1;
			iow_seen <= 1'b0;
			wr_valid_out <= 1'b0;
			wr_data_out <= '0;
		end else begin
			iow_d <= iow_s;
			if (!iow_s && (sel || acked)) begin
				wr_data_out <= sd_s;
			end
			iow_seen <= !iow_s && (sel || acked) || iow_seen && !iow_s;
			wr_valid_out <= iow_seen && iow_s && !iow_d;
		end
	end

	// request stays up until the transfer ends with terminal count
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			drq <= 1'b0;
			bus.card_drq <= 8'h00;
			dma_busy_out <= 1'b0;
		end else begin
			if (dma_req_in) begin
				drq <= 1'b1;
			end else if (rstdrv_s || acked && tc_s) begin
				drq <= 1'b0;
			end
			bus.card_drq <= 8'(drq) << DMA_CH;
			dma_busy_out <= drq;
		end
	end

	// mastership is cut at the limit so refresh can resume
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mcnt <= '0;
			bus.card_master_n <= 1'b1;
			master_cut_out <= 1'b0;
		end else begin
			master_cut_out <= 1'b0;
			if (!master_req_in || rstdrv_s) begin
				mcnt <= '0;
				bus.card_master_n <= 1'b1;
			end else if (mcnt < 11'(MASTER_MAX_CYC - 1)) begin
				mcnt <= mcnt + 11'h001;
				bus.card_master_n <= 1'b0;
			end else begin
				bus.card_master_n <= 1'b1;
				master_cut_out <= !bus.card_master_n;
			end
		end
	end
endmodule // isa_card_end

// ---- verification/isa_link_monitor.sv ----
// concurrent checks on the expansion bus wires between host end and card end
`timescale 1ns/1ps
module isa_link_monitor (
	input logic        clk_sys_in,
	input logic        rst_in,
	input logic        rstdrv,
	input logic        bale,
	input logic        aen,
	input logic        tc,
	input logic        smemr_n,
	input logic        smemw_n,
	input logic [7:0]  dack_n,
	input logic [19:0] sa,
	input logic [6:0]  la,
	input logic        ior_n,
	input logic        iow_n,
	input logic        memr_n,
	input logic        memw_n,
	input logic        refresh_n
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	wire io_cmd = !ior_n || !iow_n;

	chk_rst_drive: assert property (disable iff (1'b0) rst_in |-> rstdrv)
		else $error("reset drive low while reset held");
	chk_dma_bale: assert property (dack_n != 8'hFF |-> bale)
		else $error("latch strobe low during dma");
	chk_dma_aen: assert property (dack_n != 8'hFF |-> aen)
		else $error("address enable low during dma");
	chk_dack_one: assert property ($onehot0(~dack_n) && dack_n[4])
		else $error("more than one acknowledge low");
	chk_low_meg: assert property (refresh_n && (!smemr_n || !smemw_n) |-> la[6:3] == 4'h0)
		else $error("system memory strobe above one megabyte");
	chk_sys_mem: assert property (!(memr_n && !smemr_n) && !(memw_n && !smemw_n))
		else $error("system strobe without memory strobe");
	chk_cmd_bale: assert property (!aen && io_cmd |-> !bale)
		else $error("command strobe while latch strobe high");
	chk_addr_hold: assert property (io_cmd && $past(io_cmd) |-> $stable({sa, la}))
		else $error("address changed under command strobe");
	chk_cmd_len: assert property ($rose(io_cmd) |-> io_cmd [*8] ##[1:40] !io_cmd)
		else $error("io strobe length out of range");
	chk_tc_dack: assert property ($rose(tc) |-> dack_n != 8'hFF && aen)
		else $error("terminal count outside dma");
	chk_refresh_cmd: assert property (!refresh_n && !memr_n |-> !aen && !smemr_n && !io_cmd)
		else $error("refresh cycle malformed");

	// main scenarios reached
	cov_tc: cover property ($rose(tc));
	cov_refresh: cover property (!refresh_n && !memr_n);
	cov_io_write: cover property ($fell(iow_n));
	cov_dma: cover property (dack_n[1] == 1'b0);
endmodule // isa_link_monitor

// ---- verification/tb_isa_expansion_bus_host.sv ----
// self-checking bench: host end and card end joined by one link
`timescale 1ns/1ps
module tb_isa_expansion_bus_host;
	import isa_pkg::*;
	logic        clk_sys_in = 0, rst_in = 0, power_good = 0, hw_reset = 0, osc_d = 0;
	logic        cyc_valid = 0, cyc_write = 0, cyc_io = 0, cyc_wide = 0;
	logic [23:0] cyc_addr = '0, dma_addr = '0;
	logic [15:0] cyc_wdata = '0, rd_data = '0, wr_data, done_rdata, d, r;
	logic        cyc_ready, done_valid, done_dma, done_wide, dma_tc, chck_err, irq_any, wr_valid, dma_busy, master_cut;
	logic        dma_load = 0, dma_to_io = 0, irq = 0, parity_err = 0, dma_req = 0, master_req = 0;
	logic [2:0]  dma_ch;
	logic [3:0]  irq_num;
	logic [17:0] e;
	logic [17:0] q_host [$];
	logic [15:0] q_card [$];
	logic [24:0] spots [4] = '{25'h100_0310, 25'h0F_FFFE, 25'h10_0000, 25'hFF_FFFE};
	int          n_mismatch = 0, cmp_count = 0, cycles = 0, seed = 83, n, n_dma = 0, n_osc = 0, o;
	longint      x;

	isa_link_if link ();
	isa_host_end isa_host_end_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(link.host),
		.power_good_in(power_good), .hw_reset_in(hw_reset), .cyc_valid_in(cyc_valid), .cyc_write_in(cyc_write),
		.cyc_io_in(cyc_io), .cyc_wide_in(cyc_wide), .cyc_addr_in(cyc_addr), .cyc_wdata_in(cyc_wdata),
		.cyc_ready_out(cyc_ready), .done_valid_out(done_valid), .done_dma_out(done_dma), .done_wide_out(done_wide),
		.done_rdata_out(done_rdata), .dma_load_in(dma_load), .dma_load_ch_in(3'h1), .dma_load_cnt_in(16'h0002),
		.dma_addr_in(dma_addr), .dma_to_io_in(dma_to_io), .dma_tc_out(dma_tc), .dma_ch_out(dma_ch),
		.chck_err_out(chck_err), .irq_any_out(irq_any), .irq_num_out(irq_num));
	isa_card_end isa_card_end_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus(link.card), .rd_data_in(rd_data),
		.wr_valid_out(wr_valid), .wr_data_out(wr_data), .irq_in(irq), .parity_err_in(parity_err),
		.dma_req_in(dma_req), .dma_busy_out(dma_busy), .master_req_in(master_req), .master_cut_out(master_cut));
	isa_link_monitor isa_link_monitor_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .rstdrv(link.rstdrv),
		.bale(link.bale), .aen(link.aen), .tc(link.tc), .smemr_n(link.smemr_n), .smemw_n(link.smemw_n),
		.dack_n(link.dack_n), .sa(link.sa), .la(link.la), .ior_n(link.ior_n), .iow_n(link.iow_n),
		.memr_n(link.memr_n), .memw_n(link.memw_n), .refresh_n(link.refresh_n));

	always #4 clk_sys_in = ~clk_sys_in;

	task automatic check(input string what, input logic [15:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic hold_rst(input logic pg, hr, exp);
		power_good <= pg;
		hw_reset <= hr;
		repeat (12) @(posedge clk_sys_in);
		check("reset drive", {15'h0000, exp}, {15'h0000, link.rstdrv});
	endtask

	// exp holds {data checked, wide flag, read data}; valid stays up until taken
	task automatic cyc(input logic w, io, input logic [23:0] a, input logic [15:0] wd, input logic [17:0] exp);
		@(posedge clk_sys_in);
		{cyc_valid, cyc_write, cyc_io, cyc_wide} <= {1'b1, w, io, io};
		cyc_addr <= a;
		cyc_wdata <= wd;
		q_host.push_back(exp);
		if (w && io && a == 24'h00_0300) q_card.push_back(wd);
		do @(posedge clk_sys_in); while (cyc_ready !== 1'b1);
		cyc_valid <= 1'b0;
	endtask

	task automatic drain();
		while (q_host.size() || q_card.size()) @(posedge clk_sys_in);
		repeat (12) @(posedge clk_sys_in);
	endtask

	// results are matched against the oldest note; timeout also lands here
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 12000) begin
			n_mismatch++;
			summarize();
		end
		if (link.osc === 1'b1 && osc_d !== 1'b1) n_osc++;
		osc_d = link.osc;
		if (done_valid === 1'b1 && done_dma === 1'b1) n_dma++;
		if (done_valid === 1'b1 && done_dma !== 1'b1) begin
			e = q_host.size() ? q_host.pop_front() : 18'h3_FFFF;
			check("wide flag", {15'h0000, e[16]}, {15'h0000, done_wide});
			if (e[17]) check("read data", e[15:0], done_rdata);
		end
		if (wr_valid === 1'b1) check("card write", q_card.size() ? q_card.pop_front() : ~wr_data, wr_data);
	end

	initial begin
		// raised late in time zero so the async reset sees a real edge
		rst_in <= 1'b1;
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		hold_rst(1'b0, 1'b0, 1'b1);
		hold_rst(1'b1, 1'b0, 1'b0);
		hold_rst(1'b1, 1'b1, 1'b1);
		hold_rst(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			d = 16'($random(seed));
			r = 16'($random(seed));
			rd_data <= r;
			cyc(1'b1, 1'b1, 24'h00_0300, d, {2'b01, 16'h0000});
			cyc(1'b0, 1'b1, 24'h00_0300, d, {2'b11, r});
			drain();
		end
		// nobody answers here, so reads see the pull-ups
		foreach (spots[i]) begin
			cyc(1'b1, spots[i][24], spots[i][23:0], 16'($random(seed)), {2'b00, 16'h0000});
			cyc(1'b0, spots[i][24], spots[i][23:0], 16'h0000, {2'b10, 16'hFFFF});
		end
		drain();
		dma_addr <= 24'h00_4000;
		// first pass reads the card into memory, second writes memory data to it
		for (int k = 0; k < 2; k++) begin
			d = 16'($random(seed));
			cyc_wdata <= d;
			dma_to_io <= 1'(k);
			if (k == 1) repeat (2) q_card.push_back(d);
			n_dma = 0;
			@(posedge clk_sys_in) dma_load <= 1'b1;
			@(posedge clk_sys_in) dma_load <= 1'b0;
			dma_req <= 1'b1;
			@(posedge clk_sys_in) dma_req <= 1'b0;
			do @(posedge clk_sys_in); while (dma_tc !== 1'b1);
			repeat (20) @(posedge clk_sys_in);
			check("dma channel", 16'h0001, {13'h0000, dma_ch});
			check("dma transfers", 16'h0002, 16'(n_dma));
			check("dma request cleared", 16'h0000, {15'h0000, dma_busy});
		end
		{parity_err, irq} <= 2'b11;
		repeat (10) @(posedge clk_sys_in);
		check("channel check", 16'h0001, {15'h0000, chck_err});
		check("irq number", 16'h0015, {11'h000, irq_any, irq_num});
		{parity_err, irq} <= 2'b00;
		repeat (10) @(posedge clk_sys_in);
		check("check and irq idle", 16'h0000, {14'h0000, chck_err, irq_any});
		master_req <= 1'b1;
		o = n_osc;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (master_cut !== 1'b1);
		check("master hold window", 16'h0001, {15'h0000, n >= 1870 && n <= 1885});
		x = (longint'(n) * OSC_HZ * CLK_PERIOD_NS) / 1_000_000_000;
		check("osc edges", 16'h0001, {15'h0000, n_osc - o >= x - 1 && n_osc - o <= x + 1});
		master_req <= 1'b0;
		repeat (12) @(posedge clk_sys_in);
		rd_data <= 16'h5A_C3;
		cyc(1'b0, 1'b1, 24'h00_0300, 16'h0000, {2'b11, 16'h5A_C3});
		drain();
		summarize();
	end
endmodule // tb_isa_expansion_bus_host
